/* File: rtl/pmm_pkg.sv */
package pmm_pkg;

  // Clock and scan timing
  localparam int CLK_PERIOD_NS  = 50;
  localparam int SCAN_PERIOD_NS = 1000000;
  localparam int SCAN_CYCLES    = SCAN_PERIOD_NS / CLK_PERIOD_NS;
  localparam int MS_PER_SCAN    = SCAN_PERIOD_NS / 1000000;

  // Limit ranges in ms
  localparam int SKEW_MAX_S = 4;
  localparam int MUTE_MAX_MIN = 10;
  localparam logic signed [31:0] SKEW_MAX_MS = 32'(SKEW_MAX_S * 1000);
  localparam logic signed [31:0] MUTE_MAX_MS = 32'(MUTE_MAX_MIN * 60 * 1000);
  localparam logic [31:0] STEP_MS = 32'(MS_PER_SCAN);

  // Register map (byte addresses)
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_SKEW_A = 8'h04;
  localparam logic [7:0] OFS_SKEW_B = 8'h08;
  localparam logic [7:0] OFS_MUTE   = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_DIAG   = 8'h14;
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] SKEW_RST   = 32'h0000_01F4;
  localparam logic [31:0] MUTE_RST   = 32'h0000_EA60;
  localparam int CTRL_ACTIVATE = 0;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Diagnostic codes
  localparam logic [15:0] CODE_IDLE   = 16'h0000;
  localparam logic [15:0] CODE_RESET1 = 16'hC001;
  localparam logic [15:0] CODE_RESET2 = 16'hC002;
  localparam logic [15:0] CODE_LAMP   = 16'hC003;
  localparam logic [15:0] CODE_PARAM  = 16'hC005;
  localparam logic [15:0] CODE_MUTE   = 16'hC006;
  localparam logic [15:0] CODE_SKEW_A = 16'hC007;
  localparam logic [15:0] CODE_SKEW_B = 16'hC008;
  localparam logic [3:0]  SEQ_HEAD    = 4'hC;
  localparam logic [3:0]  SEQ_TAIL    = 4'h4;
  localparam logic [3:0]  DIG_PERMIT  = 4'hF;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00000, ST_INIT = 5'b00001, ST_WAIT = 5'b00011, ST_FREE = 5'b00010,
    ST_F11  = 5'b00110, ST_F311 = 5'b00111, ST_F12  = 5'b00101, ST_F14  = 5'b00100,
    ST_F314 = 5'b01100, ST_F21  = 5'b01101, ST_B122 = 5'b01111, ST_B422 = 5'b01110,
    ST_B121 = 5'b01010, ST_B114 = 5'b01011, ST_B414 = 5'b01001, ST_B112 = 5'b01000,
    ST_ERR  = 5'b11000
  } pmm_state_t;

endpackage : pmm_pkg

/* File: rtl/pmm_cfg_if.sv */
`timescale 1ns/1ps
interface pmm_cfg_if;
  import pmm_pkg::*;
  logic               activate;
  logic signed [31:0] skew_a_lim;
  logic signed [31:0] skew_b_lim;
  logic signed [31:0] mute_lim;
  pmm_state_t         state;
  logic [3:0]         flags;
  logic [15:0]        diag;
  modport regs (output activate, skew_a_lim, skew_b_lim, mute_lim, input state, flags, diag);
  modport core (input activate, skew_a_lim, skew_b_lim, mute_lim, output state, flags, diag);
endinterface : pmm_cfg_if

/* File: rtl/pmm_scan.sv */
`timescale 1ns/1ps
module pmm_scan #(
  parameter int CYCLES = pmm_pkg::SCAN_CYCLES
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Scan enable
  output logic      tick
);
  import pmm_pkg::*;

  logic [31:0] cnt_q;
  wire         wrap = (cnt_q == 32'(CYCLES - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end else begin
      cnt_q <= wrap ? '0 : cnt_q + 32'd1;
      tick  <= wrap;
    end
  end
endmodule : pmm_scan

/* File: rtl/pmm_axil.sv */
`timescale 1ns/1ps
module pmm_axil (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Core side
  pmm_cfg_if.regs          cfg
);
  import pmm_pkg::*;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      if (be[i]) old[i*8 +: 8] = nw[i*8 +: 8];
    end
    return old;
  endfunction : merge

  logic [31:0] ctrl_q, skew_a_q, skew_b_q, mute_q;
  logic [7:0]  wa_q;
  logic [31:0] wd_q;
  logic [3:0]  ws_q;
  logic        aw_got_q, w_got_q;

  wire do_wr  = aw_got_q && w_got_q && !s_axi_bvalid;
  wire wr_hit = (wa_q == OFS_CTRL) || (wa_q == OFS_SKEW_A) || (wa_q == OFS_SKEW_B)
                || (wa_q == OFS_MUTE);
  wire rd_go  = s_axi_arvalid && s_axi_arready;
  wire rd_hit = (s_axi_araddr == OFS_STATUS) || (s_axi_araddr == OFS_DIAG)
                || (s_axi_araddr == OFS_CTRL) || (s_axi_araddr == OFS_SKEW_A)
                || (s_axi_araddr == OFS_SKEW_B) || (s_axi_araddr == OFS_MUTE);
  wire [31:0] rd_val =
      (s_axi_araddr == OFS_CTRL)   ? ctrl_q :
      (s_axi_araddr == OFS_SKEW_A) ? skew_a_q :
      (s_axi_araddr == OFS_SKEW_B) ? skew_b_q :
      (s_axi_araddr == OFS_MUTE)   ? mute_q :
      (s_axi_araddr == OFS_STATUS) ? {23'h00_0000, cfg.state, cfg.flags} :
      (s_axi_araddr == OFS_DIAG)   ? {16'h0000, cfg.diag} : 32'h0000_0000;

  assign cfg.activate   = ctrl_q[CTRL_ACTIVATE];
  assign cfg.skew_a_lim = skew_a_q;
  assign cfg.skew_b_lim = skew_b_q;
  assign cfg.mute_lim   = mute_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0; w_got_q <= 1'b0; wa_q <= '0; wd_q <= '0; ws_q <= '0;
      s_axi_awready <= 1'b0; s_axi_wready <= 1'b0;
      s_axi_bvalid  <= 1'b0; s_axi_bresp  <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_got_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_got_q && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1; wa_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1; wd_q <= s_axi_wdata; ws_q <= s_axi_wstrb;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0; aw_got_q <= 1'b0; w_got_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CTRL_RST; skew_a_q <= SKEW_RST; skew_b_q <= SKEW_RST; mute_q <= MUTE_RST;
    end else if (do_wr) begin
      if (wa_q == OFS_CTRL)   ctrl_q   <= merge(ctrl_q, wd_q, ws_q);
      if (wa_q == OFS_SKEW_A) skew_a_q <= merge(skew_a_q, wd_q, ws_q);
      if (wa_q == OFS_SKEW_B) skew_b_q <= merge(skew_b_q, wd_q, ws_q);
      if (wa_q == OFS_MUTE)   mute_q   <= merge(mute_q, wd_q, ws_q);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0; s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0; s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !rd_go;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_val;
        s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : pmm_axil

/* File: rtl/pmm_monitor.sv */
// Summary of operation
// - Skew limit outside zero to four seconds errors.
// - Duration limit outside zero to ten minutes errors.
// - Pair activation gap beyond its limit errors.
// - Muting held beyond duration limit errors.
// - Illegal sensor change order is an error.
// - Sequence starting without permit is an error.
// - Lamp reporting failure gives lamp error C003.
// - Reset already high in init/wait errors.
// - Error drops both outputs, flags, keeps ready.
// - Resume only after clearing and operator reset.
// - Reset high on init entry gives C001.
// - Reset high on wait entry gives C002.
// - Sequence code is C, state, sensors, 4.
// - Forward states map to digits one to six.
// - Backward states map to digits seven to C.
// - Missing permit when leaving the free state uses state digit F.
// - Sensor nibble holds sensors, a1 low, b2 high.
// - Out-of-range limits report C005.
// - Muting beyond duration limit reports C006.
// - Pair skew timeouts report C007 and C008.
//
// Implementation choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module pmm_monitor #(
  parameter int SCAN_CYCLES = pmm_pkg::SCAN_CYCLES
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data and response
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Muting sensors and field inputs
  input  wire logic        sensor_a1,
  input  wire logic        sensor_a2,
  input  wire logic        sensor_b1,
  input  wire logic        sensor_b2,
  input  wire logic        muting_permit,
  input  wire logic        lamp_ok_in,
  input  wire logic        op_reset_in,
  // Safety outputs and diagnostics
  output logic             ready_out,
  output logic             error_out,
  output logic             guard_release_out,
  output logic             muting_active_out,
  output logic [15:0]      diagnostic_code
);
  import pmm_pkg::*;

  function automatic logic [3:0] state_digit(input pmm_state_t st);
    case (st)
      ST_F11:  return 4'h1;
      ST_F311: return 4'h2;
      ST_F12:  return 4'h3;
      ST_F14:  return 4'h4;
      ST_F314: return 4'h5;
      ST_F21:  return 4'h6;
      ST_B122: return 4'h7;
      ST_B422: return 4'h8;
      ST_B121: return 4'h9;
      ST_B114: return 4'hA;
      ST_B414: return 4'hB;
      ST_B112: return 4'hC;
      default: return 4'h0;
    endcase
  endfunction : state_digit

  function automatic logic [15:0] state_code(input pmm_state_t st);
    case (st)
      ST_INIT: return 16'h8001;
      ST_WAIT: return 16'h8003;
      ST_FREE: return 16'h8000;
      ST_F11:  return 16'h8011;
      ST_F311: return 16'h8311;
      ST_F12:  return 16'h8012;
      ST_F14:  return 16'h8014;
      ST_F314: return 16'h8314;
      ST_F21:  return 16'h8021;
      ST_B122: return 16'h8122;
      ST_B422: return 16'h8422;
      ST_B121: return 16'h8121;
      ST_B114: return 16'h8114;
      ST_B414: return 16'h8414;
      ST_B112: return 16'h8112;
      default: return CODE_IDLE;
    endcase
  endfunction : state_code

  function automatic logic in_range(input logic signed [31:0] v,
                                    input logic signed [31:0] hi);
    return (v >= 32'sh0000_0000) && (v <= hi);
  endfunction : in_range

  pmm_cfg_if cfg ();
  logic      tick;

  pmm_axil u_regs (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .cfg           (cfg.regs)
  );

  pmm_scan #(.CYCLES(SCAN_CYCLES)) u_scan (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (tick)
  );

  pmm_state_t  state_q, state_d;
  logic [15:0] err_code_q, err_code_d;
  logic [3:0]  prev_q;
  logic        rst_prev_q;
  logic [31:0] skew_q, mute_q;

  // Sensor levels and per-scan edges
  wire [3:0] lvl  = {sensor_b2, sensor_b1, sensor_a2, sensor_a1};
  wire [3:0] rise = lvl & ~prev_q;
  wire [3:0] fall = ~lvl & prev_q;
  wire       sensor_a1_level = lvl[0];
  wire       sensor_a2_level = lvl[1];
  wire       sensor_b1_level = lvl[2];
  wire       sensor_b2_level = lvl[3];
  wire       any_rise = |rise;
  wire       rst_rise = op_reset_in && !rst_prev_q;
  wire       rst_stuck = op_reset_in && rst_prev_q;

  wire params_ok = in_range(cfg.skew_a_lim, SKEW_MAX_MS)
                   && in_range(cfg.skew_b_lim, SKEW_MAX_MS)
                   && in_range(cfg.mute_lim, MUTE_MAX_MS);

  // Phase groupings
  wire seq_st  = (state_q != ST_IDLE) && (state_q != ST_INIT) && (state_q != ST_WAIT)
                 && (state_q != ST_FREE) && (state_q != ST_ERR);
  wire skew_a_st = (state_q == ST_F11) || (state_q == ST_F311)
                   || (state_q == ST_B114) || (state_q == ST_B414);
  wire skew_b_st = (state_q == ST_F14) || (state_q == ST_F314)
                   || (state_q == ST_B122) || (state_q == ST_B422);
  wire mute_st = seq_st && !skew_a_st && !skew_b_st || (state_q == ST_F14)
                 || (state_q == ST_F314) || (state_q == ST_B114) || (state_q == ST_B414);

  // Timeouts against the configured limits, in ms
  wire skew_to = skew_a_st && ($signed(skew_q) > cfg.skew_a_lim)
                 || skew_b_st && ($signed(skew_q) > cfg.skew_b_lim);
  wire mute_to = seq_st && ($signed(mute_q) > cfg.mute_lim);

  // Illegal patterns in the free state
  wire both_pairs = (sensor_a1_level || sensor_a2_level)
                    && (sensor_b1_level || sensor_b2_level);
  wire half_a = rise[0] && lvl[1] && !rise[1] || rise[1] && lvl[0] && !rise[0];
  wire half_b = rise[2] && lvl[3] && !rise[3] || rise[3] && lvl[2] && !rise[2];
  wire held_a = lvl[0] && !rise[0] && lvl[1] && !rise[1];
  wire held_b = lvl[2] && !rise[2] && lvl[3] && !rise[3];
  wire bad_free = both_pairs || half_a || half_b || held_a || held_b;

  // Illegal patterns per sequence state
  logic bad_seq;
  always_comb begin
    case (state_q)
      ST_FREE: bad_seq = bad_free;
      ST_F11:  bad_seq = !muting_permit || !lvl[0] || lvl[2] || lvl[3];
      ST_F311: bad_seq = !muting_permit || !lvl[1] || lvl[2] || lvl[3];
      ST_F12:  bad_seq = !lvl[0] || !lvl[1];
      ST_F14:  bad_seq = !lvl[0] || !lvl[1] || !lvl[2];
      ST_F314: bad_seq = !lvl[0] || !lvl[1] || !lvl[3];
      ST_F21:  bad_seq = any_rise;
      ST_B122: bad_seq = !muting_permit || lvl[0] || lvl[1] || !lvl[2];
      ST_B422: bad_seq = !muting_permit || lvl[0] || lvl[1] || !lvl[3];
      ST_B121: bad_seq = !lvl[2] || !lvl[3];
      ST_B114: bad_seq = !lvl[2] || !lvl[3] || !lvl[0];
      ST_B414: bad_seq = !lvl[2] || !lvl[3] || !lvl[1];
      ST_B112: bad_seq = any_rise;
      default: bad_seq = 1'b0;
    endcase
  end

  wire no_permit = (state_q == ST_FREE) && any_rise && !muting_permit;
  wire [3:0] seq_digit = bad_seq ? state_digit(state_q) : DIG_PERMIT;
  wire [15:0] seq_code = {SEQ_HEAD, seq_digit, lvl, SEQ_TAIL};
  wire lamp_bad = mute_st && !lamp_ok_in;
  // Leaving the error needs every cause gone, so a retry cannot re-mute into it
  // Reset may stay high here: a stuck button is then caught in the wait state
  // Only a fresh reset edge in the wait state restarts the free state
  wire err_clear = params_ok && lamp_ok_in && (lvl == 4'h0);

  // Normal transitions
  pmm_state_t seq_next;
  always_comb begin
    seq_next = state_q;
    case (state_q)
      ST_FREE: begin
        if (rise[0] && rise[1]) seq_next = ST_F12;
        else if (rise[0]) seq_next = ST_F11;
        else if (rise[1]) seq_next = ST_F311;
        else if (rise[2] && rise[3]) seq_next = ST_B121;
        else if (rise[2]) seq_next = ST_B122;
        else if (rise[3]) seq_next = ST_B422;
      end
      ST_F11:  if (rise[1]) seq_next = ST_F12;
      ST_F311: if (rise[0]) seq_next = ST_F12;
      ST_F12: begin
        if (&lvl) seq_next = ST_F21;
        else if (rise[2]) seq_next = ST_F14;
        else if (rise[3]) seq_next = ST_F314;
      end
      ST_F14:  if (rise[3]) seq_next = ST_F21;
      ST_F314: if (rise[2]) seq_next = ST_F21;
      ST_F21:  if (!lvl[0] && !lvl[1] && (fall[2] || fall[3])) seq_next = ST_FREE;
      ST_B122: if (rise[3]) seq_next = ST_B121;
      ST_B422: if (rise[2]) seq_next = ST_B121;
      ST_B121: begin
        if (&lvl) seq_next = ST_B112;
        else if (rise[0]) seq_next = ST_B114;
        else if (rise[1]) seq_next = ST_B414;
      end
      ST_B114: if (rise[1]) seq_next = ST_B112;
      ST_B414: if (rise[0]) seq_next = ST_B112;
      ST_B112: if (!lvl[2] && !lvl[3] && (fall[0] || fall[1])) seq_next = ST_FREE;
      default: seq_next = state_q;
    endcase
  end

  // Error priority: parameters, sequence, timers, lamp; first one latched
  always_comb begin
    state_d    = state_q;
    err_code_d = err_code_q;
    if (!cfg.activate) begin
      state_d = ST_IDLE;
    end else if (tick) begin
      case (state_q)
        ST_IDLE: state_d = ST_INIT;
        ST_ERR: if (err_clear) state_d = ST_WAIT;
        default: begin
          state_d = (state_q == ST_INIT || state_q == ST_WAIT) ? state_q : seq_next;
          if (!params_ok) begin
            state_d = ST_ERR; err_code_d = CODE_PARAM;
          end else if (state_q == ST_INIT) begin
            if (rst_stuck) begin
              state_d = ST_ERR; err_code_d = CODE_RESET1;
            end else if (rst_rise) state_d = ST_FREE;
          end else if (state_q == ST_WAIT) begin
            if (rst_stuck) begin
              state_d = ST_ERR; err_code_d = CODE_RESET2;
            end else if (rst_rise) state_d = ST_FREE;
          end else if (bad_seq || no_permit) begin
            state_d = ST_ERR; err_code_d = seq_code;
          end else if (skew_to) begin
            state_d = ST_ERR;
            err_code_d = skew_a_st ? CODE_SKEW_A : CODE_SKEW_B;
          end else if (mute_to) begin
            state_d = ST_ERR; err_code_d = CODE_MUTE;
          end else if (lamp_bad) begin
            state_d = ST_ERR; err_code_d = CODE_LAMP;
          end
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_IDLE; err_code_q <= CODE_IDLE; prev_q <= 4'h0; rst_prev_q <= 1'b0;
    end else begin
      state_q    <= state_d;
      err_code_q <= err_code_d;
      if (tick) begin
        prev_q     <= lvl;
        rst_prev_q <= op_reset_in;
      end
    end
  end

  // Timers advance once per scan; a phase change restarts the skew count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      skew_q <= '0; mute_q <= '0;
    end else if (tick) begin
      skew_q <= ((skew_a_st || skew_b_st) && state_d == state_q) ? skew_q + STEP_MS : '0;
      mute_q <= (seq_st && state_d != ST_FREE) ? mute_q + STEP_MS : '0;
    end
  end

  // Registered outputs follow the next state
  wire d_err  = (state_d == ST_ERR);
  wire d_run  = (state_d != ST_IDLE) && (state_d != ST_INIT) && (state_d != ST_WAIT) && !d_err;
  wire d_mute = d_run && (state_d != ST_FREE) && (state_d != ST_F11) && (state_d != ST_F311)
                && (state_d != ST_B122) && (state_d != ST_B422);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ready_out <= 1'b0; error_out <= 1'b0; guard_release_out <= 1'b0;
      muting_active_out <= 1'b0; diagnostic_code <= CODE_IDLE;
    end else begin
      ready_out         <= (state_d != ST_IDLE);
      error_out         <= d_err;
      guard_release_out <= d_run;
      muting_active_out <= d_mute;
      diagnostic_code   <= d_err ? err_code_d : state_code(state_d);
    end
  end

  assign cfg.state = state_q;
  assign cfg.flags = {muting_active_out, guard_release_out, error_out, ready_out};
  assign cfg.diag  = diagnostic_code;

endmodule : pmm_monitor

/* File: sim/pmm_field.sv */
`timescale 1ns/1ps
module pmm_field (
  // Clock and bench command
  input  wire logic       aclk,
  input  wire logic [6:0] want,
  // Field levels toward the monitor
  output logic            sensor_a1,
  output logic            sensor_a2,
  output logic            sensor_b1,
  output logic            sensor_b2,
  output logic            muting_permit,
  output logic            lamp_ok_in,
  output logic            op_reset_in
);
  // Known levels from time zero, moved only after a clock edge
  initial {lamp_ok_in, muting_permit, op_reset_in} = 3'h6;
  initial {sensor_b2, sensor_b1, sensor_a2, sensor_a1} = 4'h0;
  always @(posedge aclk) begin
    {lamp_ok_in, muting_permit, op_reset_in} <= want[6:4];
    {sensor_b2, sensor_b1, sensor_a2, sensor_a1} <= want[3:0];
  end
endmodule : pmm_field

/* File: sim/pmm_chk_monitor.sv */
`timescale 1ns/1ps
module pmm_chk #(
  parameter int SCAN_CYCLES = 20
) (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Watched outputs
  input wire logic        ready_out,
  input wire logic        error_out,
  input wire logic        guard_release_out,
  input wire logic        muting_active_out,
  input wire logic [15:0] diagnostic_code
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_safe; error_out |-> ready_out && !guard_release_out && !muting_active_out; endproperty
  a_safe: assert property (p_safe) else $error("unsafe outputs");
  property p_head; error_out |-> diagnostic_code[15:12] == 4'hC; endproperty
  a_head: assert property (p_head) else $error("bad code head");
  property p_hold; error_out && $past(error_out) |-> $stable(diagnostic_code); endproperty
  a_hold: assert property (p_hold) else $error("code not latched");
  property p_ok; !error_out |-> diagnostic_code[14:12] == 3'h0; endproperty
  a_ok: assert property (p_ok) else $error("error code without error");
  property p_init; $rose(error_out) && $past(diagnostic_code) == 16'h8001
    |-> diagnostic_code inside {16'hC001, 16'hC005}; endproperty
  a_init: assert property (p_init) else $error("bad init error");
  property p_wait; $rose(error_out) && $past(diagnostic_code) == 16'h8003
    |-> diagnostic_code inside {16'hC002, 16'hC005}; endproperty
  a_wait: assert property (p_wait) else $error("bad wait error");
  property p_free; $rose(error_out) && $past(diagnostic_code) == 16'h8000
    |-> diagnostic_code[3:0] == 4'h4 || diagnostic_code == 16'hC005; endproperty
  a_free: assert property (p_free) else $error("bad free error");
  property p_leave; $fell(error_out) |-> diagnostic_code inside {16'h8003, 16'h0000}; endproperty
  a_leave: assert property (p_leave) else $error("left error wrongly");
  property p_rise; $rose(guard_release_out)
    |-> $past(diagnostic_code) inside {16'h8001, 16'h8003}; endproperty
  a_rise: assert property (p_rise) else $error("release without ack");
  c_err: cover property ($rose(error_out));
  c_mute: cover property ($rose(muting_active_out));
  c_back: cover property ($fell(error_out));
endmodule : pmm_chk

bind pmm_monitor pmm_chk #(.SCAN_CYCLES(SCAN_CYCLES)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .ready_out(ready_out), .error_out(error_out),
  .guard_release_out(guard_release_out), .muting_active_out(muting_active_out),
  .diagnostic_code(diagnostic_code));

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import pmm_pkg::*;
  localparam int SC = 20;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        sensor_a1, sensor_a2, sensor_b1, sensor_b2;
  logic        muting_permit, lamp_ok_in, op_reset_in;
  logic        ready_out, error_out, guard_release_out, muting_active_out;
  logic [15:0] diagnostic_code;
  // Field command: lamp, permit, reset, b2, b1, a2, a1
  logic [6:0]  want = 7'h60;
  int          bad_count = 0, tests_run = 0, cyc = 0;

  pmm_monitor #(.SCAN_CYCLES(SC)) uut (.*);
  pmm_field u_fld (.*);

  always #25 aclk = ~aclk;

  task complete_run;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      complete_run();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Set the field, let n scans pass, compare code and {mute,guard,error,ready}
  task gs(input logic [6:0] w, input int n, input logic [15:0] c, input logic [3:0] o);
    want <= w;
    repeat (n * SC + 2) @(posedge aclk);
    chk({12'h000, muting_active_out, guard_release_out, error_out, ready_out,
         diagnostic_code}, {12'h000, o, c});
  endtask : gs

  task axw(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, RESP_OKAY});
    @(posedge aclk);
  endtask : axw

  task axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, d);
    chk({30'h0, s_axi_rresp}, {30'h0, r});
    @(posedge aclk);
  endtask : axr

  // Clear an error, then acknowledge with a reset pulse
  task recov;
    gs(7'h60, 2, 16'h8003, 4'h1);
    gs(7'h70, 1, 16'h8000, 4'h5);
    gs(7'h60, 1, 16'h8000, 4'h5);
  endtask : recov

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axr(OFS_CTRL, CTRL_RST, RESP_OKAY);
    axr(OFS_SKEW_A, SKEW_RST, RESP_OKAY);
    axr(OFS_MUTE, MUTE_RST, RESP_OKAY);
    axr(8'h40, 32'h0000_0000, RESP_SLVERR);
    axw(OFS_SKEW_A, 32'h0000_0005);
    axw(OFS_SKEW_B, 32'h0000_0005);
    axw(OFS_CTRL, 32'h0000_0001);
    gs(7'h60, 2, 16'h8001, 4'h1);
    gs(7'h70, 1, 16'h8000, 4'h5);
    gs(7'h61, 2, 16'h8011, 4'h5);
    gs(7'h63, 2, 16'h8012, 4'hD);
    gs(7'h67, 2, 16'h8014, 4'hD);
    gs(7'h6F, 2, 16'h8021, 4'hD);
    gs(7'h6C, 2, 16'h8021, 4'hD);
    gs(7'h60, 2, 16'h8000, 4'h5);
    gs(7'h65, 2, 16'hC054, 4'h3);
    recov();
    gs(7'h41, 2, 16'hCF14, 4'h3);
    recov();
    gs(7'h61, 2, 16'h8011, 4'h5);
    gs(7'h41, 2, 16'hC114, 4'h3);
    recov();
    gs(7'h64, 2, 16'h8122, 4'h5);
    gs(7'h65, 2, 16'hC754, 4'h3);
    recov();
    gs(7'h61, 10, 16'hC007, 4'h3);
    recov();
    gs(7'h68, 10, 16'hC008, 4'h3);
    recov();
    gs(7'h63, 2, 16'h8012, 4'hD);
    gs(7'h23, 2, 16'hC003, 4'h3);
    recov();
    axw(OFS_MUTE, 32'h0000_000A);
    gs(7'h63, 14, 16'hC006, 4'h3);
    recov();
    axw(OFS_SKEW_B, 32'h0000_0FA1);
    gs(7'h60, 2, 16'hC005, 4'h3);
    axw(OFS_SKEW_B, 32'h0000_0FA0);
    recov();
    axw(OFS_MUTE, 32'h0009_27C1);
    gs(7'h60, 2, 16'hC005, 4'h3);
    axw(OFS_MUTE, 32'h0009_27C0);
    recov();
    axw(OFS_SKEW_A, 32'hFFFF_FFFF);
    gs(7'h60, 2, 16'hC005, 4'h3);
    axw(OFS_SKEW_A, 32'h0000_0000);
    recov();
    axw(OFS_CTRL, 32'h0000_0000);
    gs(7'h30, 2, 16'h0000, 4'h0);
    axw(OFS_CTRL, 32'h0000_0001);
    gs(7'h30, 3, 16'hC001, 4'h3);
    gs(7'h70, 2, 16'hC002, 4'h3);
    recov();
    complete_run();
  end
endmodule : tb_top
